// [tap_debug_comm_phy.sv]
// TAP debug-communication physical layer: TAP state machine on TCK,
// nine-bit frame register, parity and abort recognition, controller side on clk.
// Assumes the controller holds tx_data/tx_req until tx_ack and obeys rx/err pulses.
`timescale 1ns/10ps
// Contract
// - Port usable when fuse set, disable clear
// - Fuse clear or disable bit kills port
// - Debug instruction selects nine-bit frame register
// - Capture-DR loads controller data into register
// - Shift-DR shifts TDI in, TDO out
// - Update-DR latches received byte to controller
// - Eight data bits LSB first, then parity
// - 0xDB inverted parity means not ready
// - 0xEB inverted parity means receive mode empty
// - Exactly one of transmit or receive mode
// - Change on falling TCK, sample on rising
// - Transmit with request sends data, good parity
// - Receive mode sends empty, parity set
// - Transmit without request sends not-ready, parity set
// - Receive nine bits, latch valid frame at update
// - Check even parity, flag mismatch to controller
// - Parity check both modes; abort on match
// - Exception enters error until abort arrives
module tap_debug_comm_phy
    import tap_debug_comm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       tck,
    input  wire logic       tms,
    input  wire logic       tdi,
    output logic            tdo,
    output logic            tdo_oe,
    input  wire logic       tap_port_fuse,
    input  wire logic       tap_port_disable,
    input  wire logic       tx_mode,
    input  wire logic       tx_req,
    input  wire logic [7:0] tx_data,
    output logic            tx_ack,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            parity_err,
    output logic            abort_seen,
    output logic            error_state,
    output logic            debug_comm_select
);
    typedef enum logic [3:0] {
        TEST_RESET = 4'h0, RUN_IDLE   = 4'h1, SEL_DR  = 4'h2, CAP_DR   = 4'h3,
        SHIFT_DR   = 4'h4, EXIT1_DR   = 4'h5, PAUSE_DR = 4'h6, EXIT2_DR = 4'h7,
        UPD_DR     = 4'h8, SEL_IR     = 4'h9, CAP_IR  = 4'ha, SHIFT_IR = 4'hb,
        EXIT1_IR   = 4'hc, PAUSE_IR   = 4'hd, EXIT2_IR = 4'he, UPD_IR   = 4'hf
    } tap_state_t;

    tap_state_t                tap_q;
    tap_state_t                tap_d;
    logic [IR_WIDTH-1:0]       ir_shift_q;
    logic [IR_WIDTH-1:0]       ir_q;
    logic [FRAME_BITS-1:0]     frame_q;
    logic                      tdo_q;
    logic                      tdo_oe_q;
    logic [2:0]                en_sync_q;
    logic [2:0]                mode_sync_q;
    logic [2:0]                req_sync_q;
    logic                      port_en_tck;
    logic                      mode_tck;
    logic                      req_tck;
    logic [7:0]                tx_hold_q;
    logic                      tx_hold_vld_q;
    logic                      take_tgl_q;
    logic                      upd_tgl_q;
    logic [7:0]                upd_byte_q;
    logic                      upd_perr_q;
    logic                      upd_abort_q;
    logic                      upd_pulse;
    logic                      take_pulse;
    logic                      port_en;
    logic                      rx_par_ok;
    logic                      sel_tck;
    logic                      cap_data_q;
    logic                      rx_abort;
    logic                      tx_load;

    // Enable decode on the system side
    assign port_en = tap_port_fuse && !tap_port_disable;

    // Single mode input means transmit and receive cannot overlap
    // Controller levels into the TCK domain, three stages, second and third agree
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            en_sync_q   <= 3'h0;
            mode_sync_q <= 3'h0;
            req_sync_q  <= 3'h0;
        end else begin
            en_sync_q   <= {en_sync_q[1:0], port_en};
            mode_sync_q <= {mode_sync_q[1:0], tx_mode};
            req_sync_q  <= {req_sync_q[1:0], tx_hold_vld_q};
        end
    end

    // Hold last agreed value so a mismatch between stages is not taken as a change
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            port_en_tck <= 1'b0;
            mode_tck    <= 1'b0;
            req_tck     <= 1'b0;
        end else begin
            if (en_sync_q[1] == en_sync_q[2]) begin
                port_en_tck <= en_sync_q[2];
            end
            if (mode_sync_q[1] == mode_sync_q[2]) begin
                mode_tck <= mode_sync_q[2];
            end
            if (req_sync_q[1] == req_sync_q[2]) begin
                req_tck <= req_sync_q[2];
            end
        end
    end

    // Standard TAP next-state on TMS
    always_comb begin
        tap_d = tap_q;
        unique case (tap_q)
            TEST_RESET: tap_d = tms ? TEST_RESET : RUN_IDLE;
            RUN_IDLE:   tap_d = tms ? SEL_DR : RUN_IDLE;
            SEL_DR:     tap_d = tms ? SEL_IR : CAP_DR;
            CAP_DR:     tap_d = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:   tap_d = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:   tap_d = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR:   tap_d = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:   tap_d = tms ? UPD_DR : SHIFT_DR;
            UPD_DR:     tap_d = tms ? SEL_DR : RUN_IDLE;
            SEL_IR:     tap_d = tms ? TEST_RESET : CAP_IR;
            CAP_IR:     tap_d = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:   tap_d = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:   tap_d = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR:   tap_d = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:   tap_d = tms ? UPD_IR : SHIFT_IR;
            UPD_IR:     tap_d = tms ? SEL_DR : RUN_IDLE;
        endcase
    end

    // A disabled port is held in test-logic reset
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            tap_q <= TEST_RESET;
        end else if (!port_en_tck) begin
            tap_q <= TEST_RESET;
        end else begin
            tap_q <= tap_d;
        end
    end

    // Instruction register
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            ir_shift_q <= IR_RESET_VALUE;
            ir_q       <= IR_RESET_VALUE;
        end else if (tap_q == TEST_RESET) begin
            ir_shift_q <= IR_RESET_VALUE;
            ir_q       <= IR_RESET_VALUE;
        end else begin
            if (tap_q == CAP_IR) begin
                ir_shift_q <= {{(IR_WIDTH-1){1'b0}}, 1'b1};
            end else if (tap_q == SHIFT_IR) begin
                ir_shift_q <= {tdi, ir_shift_q[IR_WIDTH-1:1]};
            end
            if (tap_q == UPD_IR) begin
                ir_q <= ir_shift_q;
            end
        end
    end

    assign sel_tck = (ir_q == IR_DEBUG_COMM);

    // Frame register: capture picks data, not-ready or empty; shift LSB first
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            frame_q <= '0;
        end else if (sel_tck && tap_q == CAP_DR) begin
            if (mode_tck && req_tck) begin
                frame_q <= {^tx_hold_q, tx_hold_q};
            end else if (mode_tck) begin
                frame_q <= {~(^NOT_READY_CHAR), NOT_READY_CHAR};
            end else begin
                frame_q <= {~(^EMPTY_CHAR), EMPTY_CHAR};
            end
        end else if (sel_tck && tap_q == SHIFT_DR) begin
            frame_q <= {tdi, frame_q[FRAME_BITS-1:1]};
        end
    end

    // Remember whether this frame carries the held byte; a request that turns up
    // between capture and update must not be counted as sent
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            cap_data_q <= 1'b0;
        end else if (sel_tck && tap_q == CAP_DR) begin
            cap_data_q <= mode_tck && req_tck;
        end
    end

    // Received frame checks; parity error also covers the abort character
    assign rx_par_ok = (frame_q[PARITY_POS] == ^frame_q[DATA_BITS-1:0]);

    // Abort is only ever recognised inside a parity error, in either mode
    assign rx_abort = !rx_par_ok && (frame_q[DATA_BITS-1:0] == ABORT_CHAR);

    // Update: hand byte and flags over; checker runs in both modes
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            upd_byte_q  <= 8'h00;
            upd_perr_q  <= 1'b0;
            upd_abort_q <= 1'b0;
            upd_tgl_q   <= 1'b0;
            take_tgl_q  <= 1'b0;
        end else if (sel_tck && tap_q == UPD_DR) begin
            upd_byte_q  <= frame_q[DATA_BITS-1:0];
            upd_perr_q  <= !rx_par_ok;
            upd_abort_q <= rx_abort;
            upd_tgl_q   <= ~upd_tgl_q;
            // A byte counts as sent only if this very frame captured it
            if (cap_data_q) begin
                take_tgl_q <= ~take_tgl_q;
            end
        end
    end

    // TDO changes on the falling edge so the programmer samples it stable
    always_ff @(negedge tck or negedge resetn) begin
        if (!resetn) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            // Instruction scans show the instruction register, every other scan the frame
            tdo_q    <= (tap_q == SHIFT_IR) ? ir_shift_q[0] : frame_q[0];
            tdo_oe_q <= (tap_q == SHIFT_DR) || (tap_q == SHIFT_IR);
        end
    end

    assign tdo    = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // Events from TCK into clk as toggles; TCK must run well below clk so
    // that a toggle is never overtaken by the next one before it is seen
    tap_event_sync u_upd_sync (
        .clk    (clk),
        .resetn (resetn),
        .tgl_in (upd_tgl_q),
        .pulse  (upd_pulse)
    );

    tap_event_sync u_take_sync (
        .clk    (clk),
        .resetn (resetn),
        .tgl_in (take_tgl_q),
        .pulse  (take_pulse)
    );

    // Update fields are stable long before the toggle arrives, so sampling is safe
    // Transmit holding byte; request level goes to TCK and back as the take toggle
    // A load waits out the ack cycle so one held request is never taken twice
    assign tx_load = tx_mode && !take_pulse && tx_req && !tx_hold_vld_q && !tx_ack;

    // Holding byte; written only while empty, so TCK reads a settled word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_hold_q <= 8'h00;
        end else if (tx_load) begin
            tx_hold_q <= tx_data;
        end
    end

    // Holding valid; freed by a sent frame or by leaving transmit mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_hold_vld_q <= 1'b0;
        end else if (take_pulse || !tx_mode) begin
            tx_hold_vld_q <= 1'b0;
        end else if (tx_load) begin
            tx_hold_vld_q <= 1'b1;
        end
    end

    // Acknowledge, one clk per byte taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_ack <= 1'b0;
        end else begin
            tx_ack <= tx_load;
        end
    end

    // Controller-side pulses, one clk each
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_valid   <= 1'b0;
            parity_err <= 1'b0;
            abort_seen <= 1'b0;
        end else begin
            rx_valid   <= upd_pulse && !upd_perr_q && !tx_mode && !error_state;
            parity_err <= upd_pulse && upd_perr_q;
            abort_seen <= upd_pulse && upd_abort_q;
        end
    end

    // Received byte holds until the next clean receive-mode frame; nothing lands while in error
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_data <= 8'h00;
        end else if (upd_pulse && !upd_perr_q && !tx_mode && !error_state) begin
            rx_data <= upd_byte_q;
        end
    end

    // Error state; abort clears it even though it is itself a parity error
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            error_state <= 1'b0;
        end else if (upd_pulse && upd_abort_q) begin
            error_state <= 1'b0;
        end else if (upd_pulse && upd_perr_q) begin
            error_state <= 1'b1;
        end
    end

    // Status level into clk for software visibility
    logic [2:0] sel_sync_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_sync_q <= 3'h0;
        end else begin
            sel_sync_q <= {sel_sync_q[1:0], sel_tck};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            debug_comm_select <= 1'b0;
        end else if (sel_sync_q[1] == sel_sync_q[2]) begin
            debug_comm_select <= sel_sync_q[2];
        end
    end
endmodule : tap_debug_comm_phy

// [tap_debug_comm_pkg.sv]
// Constants for the TAP debug-communication physical layer.
// Assumes a single TCK link domain and a system clock domain.
package tap_debug_comm_pkg;
    localparam int          FRAME_BITS     = 9;
    localparam int          DATA_BITS      = 8;
    localparam int          PARITY_POS     = 8;
    localparam logic [7:0]  ABORT_CHAR     = 8'hbb;
    localparam logic [7:0]  NOT_READY_CHAR = 8'hdb;
    localparam logic [7:0]  EMPTY_CHAR     = 8'heb;
    localparam logic [3:0]  IR_WIDTH       = 4'h4;
    localparam logic [3:0]  IR_DEBUG_COMM  = 4'h7;
    localparam logic [3:0]  IR_RESET_VALUE = 4'hf;
    localparam int          SYNC_STAGES    = 3;
endpackage : tap_debug_comm_pkg

// [tap_event_sync.sv]
// Toggle-based event crossing into a destination clock domain.
// Assumes the source toggles tgl_in once per event, events spaced widely.
`timescale 1ns/10ps
module tap_event_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic tgl_in,
    output logic      pulse
);
    logic [2:0] sync_q;

    // Three flops; the edge is taken between the second and third only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], tgl_in};
        end
    end

    assign pulse = sync_q[1] ^ sync_q[2];
endmodule : tap_event_sync

// [tap_debug_comm_phy_checker.sv]
// Checker for the TAP debug-communication layer: pulses, error state, port gating.
// Assumes it is bound onto the layer's top module and sees its ports only.
`timescale 1ns/10ps
module tap_debug_comm_phy_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tdo_oe,
    input wire logic tap_port_fuse,
    input wire logic tap_port_disable,
    input wire logic tx_mode,
    input wire logic tx_req,
    input wire logic tx_ack,
    input wire logic rx_valid,
    input wire logic parity_err,
    input wire logic abort_seen,
    input wire logic error_state
);
    // Receive pulse: one cycle, clean data only, never in transmit mode; abort only with a parity fault
    AST_RX_PULSE: assert property (@(posedge clk) disable iff (!resetn) rx_valid |=> !rx_valid)
        else $error("rx_valid held past one cycle");
    AST_RX_CLEAN: assert property (@(posedge clk) disable iff (!resetn) rx_valid |-> !parity_err && !error_state)
        else $error("rx_valid with parity fault or in error");
    AST_RX_MODE: assert property (@(posedge clk) disable iff (!resetn) rx_valid |-> !$past(tx_mode))
        else $error("rx_valid in transmit mode");
    AST_ABORT_PERR: assert property (@(posedge clk) disable iff (!resetn) abort_seen |-> parity_err)
        else $error("abort without parity fault");
    // Error state enters on a fault and leaves only through an abort
    AST_ERR_SET: assert property (@(posedge clk) disable iff (!resetn)
        parity_err && !abort_seen |-> ##[0:1] error_state)
        else $error("parity fault did not enter error");
    AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!resetn) abort_seen |-> ##[0:1] !error_state)
        else $error("abort did not leave error");
    AST_ERR_RISE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(error_state) |-> parity_err || $past(parity_err))
        else $error("error entered without fault");
    AST_ERR_FALL: assert property (@(posedge clk) disable iff (!resetn)
        $fell(error_state) |-> abort_seen || $past(abort_seen))
        else $error("error left without abort");
    AST_ACK_REQ: assert property (@(posedge clk) disable iff (!resetn) tx_ack |-> $past(tx_req))
        else $error("tx_ack without request");
    // Sync latency allowed before a disabled port drops its driver
    AST_OE_OFF: assert property (@(posedge tck) disable iff (!resetn)
        (!tap_port_fuse || tap_port_disable) [*7] |-> !tdo_oe)
        else $error("tdo driven while port disabled");
    COV_RX: cover property (@(posedge clk) disable iff (!resetn) rx_valid);
    COV_ABORT: cover property (@(posedge clk) disable iff (!resetn) abort_seen);
    COV_ACK: cover property (@(posedge clk) disable iff (!resetn) tx_ack);
endmodule : tap_debug_comm_phy_checker

bind tap_debug_comm_phy tap_debug_comm_phy_checker tap_debug_comm_phy_checker_i (.clk, .resetn, .tck, .tdo_oe,
    .tap_port_fuse, .tap_port_disable, .tx_mode, .tx_req, .tx_ack, .rx_valid, .parity_err, .abort_seen, .error_state);

// [tap_programmer.sv]
// External programmer model: makes TCK only inside its step task (idle, reset and scans), drives TMS/TDI.
// Assumes the layer resets its TAP to Test-Logic-Reset and uses a 4-bit IR.
`timescale 1ns/10ps
module tap_programmer (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One TCK period: change after falling edge, sample at rising edge
    task automatic step(input logic m, input logic d, output logic got);
        tms = m;
        tdi = d;
        #62.5;
        got = tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step
    // Idle clocks in Run-Test/Idle; TDI toggles so it never looks held
    task automatic idle(input int n);
        logic g;
        repeat (n) step(1'b0, ~tdi, g);
    endtask : idle
    task automatic tap_reset();
        logic g;
        repeat (6) step(1'b1, 1'b1, g);
        step(1'b0, 1'b1, g);
    endtask : tap_reset
    // IR or DR scan from idle, LSB first, last bit with TMS high, back to idle
    task automatic scan(input logic ir, input int n, input logic [8:0] fin, output logic [8:0] fout);
        logic g;
        fout = '0;
        step(1'b1, tdi, g);
        if (ir) step(1'b1, tdi, g);
        step(1'b0, tdi, g);
        step(1'b0, tdi, g);
        for (int i = 0; i < n; i++) step(i == n - 1, fin[i], fout[i]);
        step(1'b1, ~tdi, g);
        step(1'b0, ~tdi, g);
        tdi = ~tdi;
    endtask : scan
endmodule : tap_programmer

// [tb_top.sv]
// Self-checking bench for the TAP debug-communication layer.
// Assumes the programmer model drives the TAP; clk-side inputs change at falling clk.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import tap_debug_comm_pkg::*;
    logic       clk, resetn, tck, tms, tdi, tdo, tdo_oe, tap_port_fuse, tap_port_disable, tx_mode, tx_req;
    logic       tx_ack, rx_valid, parity_err, abort_seen, error_state, debug_comm_select;
    logic [7:0] tx_data, rx_data, last_rx, b;
    logic [31:0] seed;
    logic       tdo_pin;
    int         n_mismatch, samples_checked, n_rx, n_perr, n_abort, n_ack, a;
    tap_debug_comm_phy tap_debug_comm_phy_i (.clk, .resetn, .tck, .tms, .tdi, .tdo, .tdo_oe, .tap_port_fuse,
        .tap_port_disable, .tx_mode, .tx_req, .tx_data, .tx_ack, .rx_valid, .rx_data, .parity_err, .abort_seen,
        .error_state, .debug_comm_select);
    // Undriven TDO has no pull, so the model sees the inverse when the driver is off
    assign tdo_pin = tdo_oe ? tdo : ~tdo;
    tap_programmer tap_programmer_i (.tck, .tms, .tdi, .tdo(tdo_pin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [8:0] frame(input logic [7:0] d, input logic inv);
        return {(^d) ^ inv, d};
    endfunction : frame
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin n_rx++; last_rx = rx_data; end
        if (parity_err === 1'b1) n_perr++;
        if (abort_seen === 1'b1) n_abort++;
        if (tx_ack === 1'b1) n_ack++;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // One DR frame; idle clocks first let mode levels cross into TCK
    task automatic xfer(input logic [8:0] fin, input logic [8:0] ex, input int drx, input int dpe, input int dab);
        logic [8:0] got;
        int         r0, p0, a0;
        r0 = n_rx;
        p0 = n_perr;
        a0 = n_abort;
        tap_programmer_i.idle(4);
        tap_programmer_i.scan(1'b0, 9, fin, got);
        repeat (10) @(negedge clk);
        `CHK("tdo frame", ex, got)
        `CHK("rx count", drx, n_rx - r0)
        `CHK("parity count", dpe, n_perr - p0)
        `CHK("abort count", dab, n_abort - a0)
        if (drx != 0) `CHK("rx data", fin[7:0], last_rx)
    endtask : xfer
    initial begin
        logic [8:0] g;
        {resetn, tap_port_fuse, tap_port_disable, tx_mode, tx_req, tx_data} = '0;
        seed = 32'h0277b6b1;
        fork
            repeat (8) @(negedge clk);
            tap_programmer_i.idle(2);
        join
        // Release off the edges: clk has just fallen and TCK just fallen here
        @(negedge clk);
        `CHK("reset outputs", 6'h00, {tdo_oe, tx_ack, rx_valid, parity_err, abort_seen, error_state})
        resetn = 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            tap_port_fuse = (k != 0);
            tap_port_disable = (k == 1);
            tap_programmer_i.tap_reset();
            tap_programmer_i.scan(1'b1, 4, {5'h00, IR_DEBUG_COMM}, g);
            repeat (10) @(negedge clk);
            `CHK("select", k == 2, debug_comm_select)
        end
        // Receive mode: corners, then random bytes
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
            xfer(frame(b, 1'b0), frame(EMPTY_CHAR, 1'b1), 1, 0, 0);
        end
        xfer(frame(8'h5a, 1'b1), frame(EMPTY_CHAR, 1'b1), 0, 1, 0);
        `CHK("error state", 1'b1, error_state)
        xfer(frame(8'h5a, 1'b0), frame(EMPTY_CHAR, 1'b1), 0, 0, 0);
        `CHK("rx data held", b, rx_data)
        xfer(frame(ABORT_CHAR, 1'b1), frame(EMPTY_CHAR, 1'b1), 0, 1, 1);
        `CHK("error state", 1'b0, error_state)
        @(negedge clk);
        tx_mode = 1'b1;
        xfer(frame(8'h00, 1'b0), frame(NOT_READY_CHAR, 1'b1), 0, 0, 0);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            a = n_ack;
            @(negedge clk);
            tx_data = seed[15:8];
            tx_req = 1'b1;
            fork
                tap_programmer_i.idle(12);
                begin
                    for (int w = 0; w < 200 && n_ack == a; w++) @(negedge clk);
                    tx_req = 1'b0;
                end
            join
            `CHK("ack count", a + 1, n_ack)
            // The load stays pending: scan again rather than reissue it
            xfer(frame(8'h00, 1'b0), frame(tx_data, 1'b0), 0, 0, 0);
            xfer(frame(8'h00, 1'b0), frame(NOT_READY_CHAR, 1'b1), 0, 0, 0);
        end
        xfer(frame(8'h33, 1'b1), frame(NOT_READY_CHAR, 1'b1), 0, 1, 0);
        xfer(frame(ABORT_CHAR, 1'b1), frame(NOT_READY_CHAR, 1'b1), 0, 1, 1);
        `CHK("error state", 1'b0, error_state)
        end_of_test();
    end
    // Watchdog well beyond the planned run
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_top
